/* File: src/dpsem_host.sv */
// Purpose: one port's host controller driving semaphore cycles on the pins
// Assumes: device pins treated as synchronous to core_clk
// Notes: request = write zero then read back; release = write one
`timescale 1ns/1ps
module dpsem_host (
  input  wire logic                          core_clk,
  input  wire logic                          rstn,
  input  wire logic                          cmdValid,
  input  wire logic [1:0]                    cmdOp,
  input  wire logic [dpsem_pkg::IDX_W-1:0]   cmdIndex,
  input  wire logic                          busyIn_n,
  input  wire logic [dpsem_pkg::DATA_W-1:0]  ioIn,
  output logic                               cmdReady,
  output logic                               doneValid,
  output logic                               granted,
  output logic                               semaphore_select_n,
  output logic                               memSelect_n,
  output logic                               writeEnable_n,
  output logic                               outputEnable_n,
  output logic [dpsem_pkg::IDX_W-1:0]        flag_index_lines,
  output logic [dpsem_pkg::DATA_W-1:0]       ioOut,
  output logic                               ioOutEn
);
  dpsem_pkg::dpsem_state_e                state_reg, state_next;
  logic [dpsem_pkg::CNT_W-1:0]            cnt_reg, cnt_next;
  logic [1:0]                             op_reg, op_next;
  logic [dpsem_pkg::IDX_W-1:0]            idx_reg, idx_next;
  logic                                   sem_reg, sem_next;
  logic                                   we_reg, we_next;
  logic                                   oe_reg, oe_next;
  logic                                   dout_reg, dout_next;
  logic                                   done_reg, done_next;
  logic                                   gnt_reg, gnt_next;

  // every data bit carries the one flag; all zeros means our side holds it
  function automatic logic flagOwned(input logic [15:0] d);
    flagOwned = (d == 16'h0000);
  endfunction : flagOwned

  // sequencer: the strobe waits out arbitration, stretches past busy
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    op_next    = op_reg;
    idx_next   = idx_reg;
    sem_next   = sem_reg;
    we_next    = we_reg;
    oe_next    = oe_reg;
    dout_next  = dout_reg;
    done_next  = 1'b0;
    gnt_next   = gnt_reg;
    case (state_reg)
      // waiting for a command with both selects parked high
      dpsem_pkg::DPSEM_IDLE: begin
        sem_next = 1'b1;                // standby: both selects high
        if (cmdValid) begin
          op_next   = cmdOp;
          idx_next  = cmdIndex;         // only three index lines used
          dout_next = (cmdOp != dpsem_pkg::OP_REQUEST); // zero asks
          sem_next  = 1'b0;
          cnt_next  = 4'(dpsem_pkg::ARB_CYC);
          if (cmdOp == dpsem_pkg::OP_READ) begin
            oe_next    = 1'b0;
            cnt_next   = 4'(dpsem_pkg::ACC_CYC);
            state_next = dpsem_pkg::DPSEM_READ;
          end else begin
            state_next = dpsem_pkg::DPSEM_SETUP;
          end
        end
      end
      // address and data out, strobe held back so busy can settle
      dpsem_pkg::DPSEM_SETUP: begin
        if (cnt_reg <= 4'h1) begin
          we_next    = 1'b0;
          cnt_next   = 4'(dpsem_pkg::PULSE_CYC);
          state_next = dpsem_pkg::DPSEM_STROBE;
        end else begin
          cnt_next = cnt_reg - 4'h1;
        end
      end
      // strobe low; a busy seen here pushes the rising edge out
      dpsem_pkg::DPSEM_STROBE: begin
        if (!busyIn_n) begin            // one busy, from the master
          cnt_next = 4'(dpsem_pkg::HOLD_CYC); // restart hold while busy
        end else if (cnt_reg <= 4'h1) begin
          we_next    = 1'b1;
          cnt_next   = 4'(dpsem_pkg::ACC_CYC);
          state_next = dpsem_pkg::DPSEM_HOLD;
        end else begin
          cnt_next = cnt_reg - 4'h1;
        end
      end
      // select high for a cycle so the write ends before any read
      dpsem_pkg::DPSEM_HOLD: begin
        sem_next = 1'b1;
        if (op_reg == dpsem_pkg::OP_REQUEST) begin
          state_next = dpsem_pkg::DPSEM_READ; // read back to confirm
        end else begin
          gnt_next   = 1'b0;            // a release gives the token up
          state_next = dpsem_pkg::DPSEM_DONE;
        end
      end
      // semaphore select and output enable low for the access time, then take the replicated flag
      dpsem_pkg::DPSEM_READ: begin
        sem_next = 1'b0;
        oe_next  = 1'b0;                // device latches value on this edge
        if (!sem_reg && !oe_reg) begin
          if (cnt_reg <= 4'h1) begin
            gnt_next   = flagOwned(ioIn); // replicated flag
            oe_next    = 1'b1;          // release so next poll relatches
            sem_next   = 1'b1;
            state_next = dpsem_pkg::DPSEM_DONE;
          end else begin
            cnt_next = cnt_reg - 4'h1;
          end
        end else begin
          cnt_next = 4'(dpsem_pkg::ACC_CYC);
        end
      end
      // one cycle of done, then ready again
      dpsem_pkg::DPSEM_DONE: begin
        done_next  = 1'b1;
        state_next = dpsem_pkg::DPSEM_IDLE;
      end
      default: state_next = dpsem_pkg::DPSEM_IDLE;
    endcase
  end

  // state registers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= dpsem_pkg::DPSEM_IDLE;
      cnt_reg   <= 4'h0;
      op_reg    <= 2'h0;
      idx_reg   <= 3'h0;
      sem_reg   <= 1'b1;
      we_reg    <= 1'b1;
      oe_reg    <= 1'b1;
      dout_reg  <= 1'b1;
      done_reg  <= 1'b0;
      gnt_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      op_reg    <= op_next;
      idx_reg   <= idx_next;
      sem_reg   <= sem_next;
      we_reg    <= we_next;
      oe_reg    <= oe_next;
      dout_reg  <= dout_next;
      done_reg  <= done_next;
      gnt_reg   <= gnt_next;
    end
  end

  // ready and drive look one state ahead so both leave flip-flops on time
  logic                                   cmdReady_next, ioOutEn_next;
  always_comb begin
    cmdReady_next = (state_next == dpsem_pkg::DPSEM_IDLE);
    ioOutEn_next  = (state_next == dpsem_pkg::DPSEM_SETUP) ||
                    (state_next == dpsem_pkg::DPSEM_STROBE);
  end

  // pins; memory select stays high, semaphores need no RAM access
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cmdReady <= 1'b0;
      ioOutEn  <= 1'b0;
    end else begin
      cmdReady <= cmdReady_next;
      ioOutEn  <= ioOutEn_next;
    end
  end
  // outputs other than memSelect_n come straight from the registers above
  assign memSelect_n        = 1'b1;
  assign semaphore_select_n = sem_reg;
  assign writeEnable_n      = we_reg;
  assign outputEnable_n     = oe_reg;
  assign flag_index_lines   = idx_reg;
  assign ioOut              = {15'h0000, dout_reg}; // flag_data_bit only
  assign doneValid          = done_reg;
  assign granted            = gnt_reg;

  // strobe never falls before arbitration time has passed
  a_strobe_after_arb: assert property (
    @(posedge core_clk) disable iff (!rstn)
    $fell(we_reg) |-> $past(state_reg) == dpsem_pkg::DPSEM_SETUP)
    else $error("write strobe started without arbitration wait");
  // strobe stays low for as long as busy is asserted
  a_hold_after_busy: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (!we_reg && !busyIn_n) |=> !we_reg)
    else $error("write strobe released while busy");
  // a request is always read back before it is reported
  a_request_reads: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (state_reg == dpsem_pkg::DPSEM_HOLD &&
     op_reg == dpsem_pkg::OP_REQUEST) |=> state_reg == dpsem_pkg::DPSEM_READ)
    else $error("request not followed by read-back");
  // both selects parked high whenever no command runs
  a_standby_idle: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (state_reg == dpsem_pkg::DPSEM_IDLE) |-> sem_reg && memSelect_n)
    else $error("selects active while idle");
  // a request strobes a zero onto the flag data bit
  a_request_zero: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (!we_reg && op_reg == dpsem_pkg::OP_REQUEST) |-> !dout_reg)
    else $error("request did not write zero");
  // data bit is on the pins for as long as the strobe is low
  a_drive_with_strobe: assert property (
    @(posedge core_clk) disable iff (!rstn)
    !we_reg |-> ioOutEn)
    else $error("write strobe low without data driven");
  // the read-back never overlaps a write strobe
  a_read_no_write: assert property (
    @(posedge core_clk) disable iff (!rstn)
    !oe_reg |-> we_reg)
    else $error("write strobe low during a read");
  // index lines stay put while the select stays low, so busy can settle
  a_index_steady: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (!sem_reg && !$past(sem_reg)) |-> $stable(idx_reg))
    else $error("flag index changed inside a cycle");
endmodule : dpsem_host

/* File: src/dpsem_pkg.sv */
// Purpose: constants for the host controller of a dual-port semaphore RAM
// Assumes: core_clk at 40 MHz; device pins treated as synchronous to core_clk
// Notes: How it works list below
// How it works
// - system keeps a single arbitrator, on the master chip of a cascade
// - host holds slave writes off until busy inputs have settled
// - host keeps write strobe low a hold time after busy releases
// - host delays slave write strobe by master's worst arbitration time
// - flags active low: write zero requests, write one releases
// - after requesting, host reads flag back to confirm ownership
package dpsem_pkg;
  localparam int CLK_MHZ      = 40;
  localparam int ARB_NS       = 30;   // master worst-case arbitration time
  localparam int HOLD_NS      = 20;   // write hold after busy release
  localparam int PULSE_NS     = 30;   // least write strobe width
  localparam int ACC_NS       = 45;   // read access time
  localparam int ARB_CYC   = (ARB_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLD_CYC  = (HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int PULSE_CYC = (PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int ACC_CYC   = (ACC_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W     = 4;
  localparam int IDX_W     = 3;
  localparam int DATA_W    = 16;
  localparam logic [1:0] OP_RELEASE = 2'h0;
  localparam logic [1:0] OP_REQUEST = 2'h1;
  localparam logic [1:0] OP_READ    = 2'h2;
  typedef enum logic [2:0] {
    DPSEM_IDLE   = 3'b000,
    DPSEM_SETUP  = 3'b001,
    DPSEM_STROBE = 3'b010,
    DPSEM_HOLD   = 3'b011,
    DPSEM_READ   = 3'b100,
    DPSEM_DONE   = 3'b101
  } dpsem_state_e;
endpackage : dpsem_pkg

/* File: testbench/dpsem_dev_model.sv */
// Purpose: behavioural model of one port of the semaphore device
// Assumes: far side requests arrive from the bench as one-cycle pulses
// Notes: pins sampled on core_clk; no main memory array is modelled
`timescale 1ns/1ps
module dpsem_dev_model (
  input  wire logic        core_clk,
  input  wire logic        semaphore_select_n,
  input  wire logic        writeEnable_n,
  input  wire logic        outputEnable_n,
  input  wire logic [2:0]  flag_index_lines,
  input  wire logic [15:0] ioOut,
  input  wire logic        busyIn_n,
  input  wire logic        farReq,
  input  wire logic        farBit,
  input  wire logic [2:0]  farIdx,
  output logic      [15:0] ioIn
);
  // eight flags held apart from any memory, per-side request latches
  logic [7:0] nearReq = 8'h0, farLatch = 8'h0, nearOwns = 8'h0;
  logic [7:0] farOwns = 8'h0;
  logic       rdBit = 1'b1, rdHeld = 1'b0, wePrev = 1'b1, dBit = 1'b1;
  // zero requests, one releases; a locked-out zero waits
  task automatic apply(input logic far, input logic [2:0] i, input logic b);
    if (far) farLatch[i] = !b;
    else nearReq[i] = !b;
    if (nearOwns[i] && !nearReq[i]) nearOwns[i] = 1'b0;
    if (farOwns[i] && !farLatch[i]) farOwns[i] = 1'b0;
    if (!nearOwns[i] && !farOwns[i]) begin
      farOwns[i] = farLatch[i] && (far || !nearReq[i]);
      nearOwns[i] = nearReq[i] && !farOwns[i];
    end
  endtask : apply
  // write ends at strobe rise; busy input voids it
  always @(posedge core_clk) begin
    wePrev <= writeEnable_n;
    if (!writeEnable_n) dBit <= ioOut[0];
    if (writeEnable_n && !wePrev && !semaphore_select_n && busyIn_n)
      apply(1'b0, flag_index_lines, dBit);
    if (farReq) apply(1'b1, farIdx, farBit); // ports independent
    if (semaphore_select_n || outputEnable_n) rdHeld <= 1'b0;
    else if (!rdHeld) begin
      rdHeld <= 1'b1;
      rdBit <= !nearOwns[flag_index_lines]; // frozen while read
    end
  end
  // flag on every bit; undriven bus shows the inverse so stale data fails
  assign ioIn = (rdHeld && !outputEnable_n) ? {16{rdBit}} : {16{!rdBit}};
endmodule : dpsem_dev_model

/* File: testbench/testbench.sv */
// Purpose: self-checking bench for the semaphore host controller
// Assumes: device model stands in for one port of the dual-port part
// Notes: far side requests are issued by the bench through the model
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
  n_mismatch++; $display("unexpected %s expected %h seen %h", nm, e, g); end end
module testbench;
  logic        core_clk = 0, rstn = 0, cmdValid = 0, busyN = 1, farReq = 0;
  logic        farBit = 1, cmdReady, doneValid, granted, semN, memN, weN;
  logic        oeN, ioOutEn;
  logic [1:0]  cmdOp = 2'h0;
  logic [2:0]  cmdIndex = 3'h0, farIdx = 3'h0, idxLines;
  logic [15:0] ioIn, ioOut;
  int          n_mismatch = 0, comparisons = 0;
  always #12.5 core_clk = ~core_clk;
  dpsem_host dut (.core_clk(core_clk), .rstn(rstn), .cmdValid(cmdValid),
    .cmdOp(cmdOp), .cmdIndex(cmdIndex), .busyIn_n(busyN), .ioIn(ioIn),
    .cmdReady(cmdReady), .doneValid(doneValid), .granted(granted),
    .semaphore_select_n(semN), .memSelect_n(memN), .writeEnable_n(weN),
    .outputEnable_n(oeN), .flag_index_lines(idxLines), .ioOut(ioOut),
    .ioOutEn(ioOutEn));
  dpsem_dev_model model (.core_clk(core_clk), .semaphore_select_n(semN),
    .writeEnable_n(weN), .outputEnable_n(oeN), .flag_index_lines(idxLines),
    .ioOut(ioOut), .busyIn_n(busyN), .farReq(farReq), .farBit(farBit),
    .farIdx(farIdx), .ioIn(ioIn));
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test
  // one command; busy held low for stall cycles once the strobe falls
  task automatic cmd(input logic [1:0] op, input logic [2:0] ix, int stall);
    int c, s, w, post;
    s = -1;
    w = -1;
    post = 0;
    @(posedge core_clk);
    cmdValid <= 1'b1;
    cmdOp <= op;
    cmdIndex <= ix;
    for (c = 0; c < 80; c++) begin
      @(posedge core_clk);
      cmdValid <= 1'b0;
      busyN <= !(stall > 0 && w >= 0 && c > w && c <= w + stall);
      #1;
      if (s < 0 && semN === 1'b0) s = c;
      if (w < 0 && weN === 1'b0) w = c;
      if (w >= 0 && c > w + stall && busyN && weN === 1'b0) post++;
      if (!busyN) `CHK("strobe under busy", 1'b0, weN)
      if (weN === 1'b0) `CHK("drive", 1'b1, ioOutEn)
      if (weN === 1'b0)
        `CHK("flag bit", op != dpsem_pkg::OP_REQUEST, ioOut[0])
      if (doneValid === 1'b1) break;
    end
    if (c >= 80) begin
      n_mismatch++;
      finish_test();
    end
    if (op != dpsem_pkg::OP_READ)
      `CHK("arb gap", 1'b1, w - s >= dpsem_pkg::ARB_CYC)
    if (stall > 0) `CHK("hold", 1'b1, post >= dpsem_pkg::HOLD_CYC)
  endtask : cmd
  task automatic far(input logic [2:0] ix, input logic b);
    @(posedge core_clk);
    farReq <= 1'b1;
    farIdx <= ix;
    farBit <= b;
    @(posedge core_clk);
    farReq <= 1'b0;
  endtask : far
  task automatic t_own;
    cmd(dpsem_pkg::OP_REQUEST, 3'h3, 0);
    `CHK("granted", 1'b1, granted)
    cmd(dpsem_pkg::OP_READ, 3'h3, 0);
    `CHK("reread", 1'b1, granted)
    cmd(dpsem_pkg::OP_RELEASE, 3'h3, 4);
    `CHK("released", 1'b0, granted)
    `CHK("standby", 1'b1, semN)
    $display("test own done");
  endtask : t_own
  task automatic t_all;
    for (int i = 0; i < 8; i++) begin
      far(3'(i + 1), 1'b0);
      cmd(dpsem_pkg::OP_REQUEST, 3'(i), 0);
      `CHK("flag index", 1'b1, granted)
      cmd(dpsem_pkg::OP_RELEASE, 3'(i), 0);
      far(3'(i + 1), 1'b1);
    end
    $display("test index done");
  endtask : t_all
  task automatic t_lock;
    far(3'h5, 1'b0);
    cmd(dpsem_pkg::OP_REQUEST, 3'h5, 0);
    `CHK("locked out", 1'b0, granted)
    far(3'h5, 1'b1);
    cmd(dpsem_pkg::OP_READ, 3'h5, 0);
    `CHK("handed over", 1'b1, granted)
    cmd(dpsem_pkg::OP_RELEASE, 3'h5, 0);
    $display("test lockout done");
  endtask : t_lock
  initial begin
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    #1;
    `CHK("ready", 1'b1, cmdReady)
    `CHK("mem select", 1'b1, memN)
    t_own();
    t_all();
    t_lock();
    finish_test();
  end
endmodule : testbench
